// *** logic/pp_regs_consts.vh ***
// Purpose: constants for the parallel port register block
// Assumes: one system clock at 200 MHz
// Notes: offsets are host byte addresses from the port base
`ifndef PP_REGS_CONSTS_VH
`define PP_REGS_CONSTS_VH

// ==========================================================
// register offsets
`define PP_OFF_DATA 3'h0
`define PP_OFF_STAT 3'h1
`define PP_OFF_CTRL 3'h2
`define PP_OFF_EADDR 3'h3
`define PP_OFF_EDATA0 3'h4

// ==========================================================
// status field positions
`define PP_ST_EXPIRED 0
`define PP_ST_FAULT 3
`define PP_ST_ONLINE 4
`define PP_ST_MEDIA 5
`define PP_ST_ACK 6
`define PP_ST_READY 7

// ==========================================================
// control field positions
`define PP_CT_STROBE 0
`define PP_CT_LINEFEED 1
`define PP_CT_PRST 2
`define PP_CT_CHOOSE 3
`define PP_CT_IRQ 4
`define PP_CT_DIR 5

// ==========================================================
// reset values
`define PP_DATA_RST 8'h00
`define PP_CTRL_RST 6'h00
`define PP_EADDR_RST 8'h00
`define PP_EDATA_RST 8'h00
// strobes and active-low pins idle high
`define PP_SYNC_RST 27'h2780000

// ==========================================================
// port modes
`define PP_MODE_PRINTER 2'h0
`define PP_MODE_BIDIR 2'h1
`define PP_MODE_EPP 2'h2
`define PP_MODE_ECP 2'h3

// ==========================================================
// timing
`define PP_CLK_PS 5000
`define PP_TMO_NS 10000
`define PP_TMO_CYC ((`PP_TMO_NS * 1000) / `PP_CLK_PS)

`endif

// *** logic/pp_regs.v ***
// Purpose: host register logic of a multi-mode parallel port
// Assumes: host strobes and connector inputs are asynchronous to clk_sys
// Notes: host strobes are seen after a three-flop filter, so edges lag
`timescale 1ns/10ps
`include "pp_regs_consts.vh"

module pp_regs #(
   parameter TMO_CYC = `PP_TMO_CYC
) (
   input wire clk_sys,
   input wire reset,
   input wire [1:0] port_mode,
   input wire host_cs_n,
   input wire host_rd_n,
   input wire host_wr_n,
   input wire [2:0] host_addr,
   input wire [7:0] host_data_in,
   output reg [7:0] host_data_out,
   output reg host_data_oe,
   output reg host_chrdy,
   output reg host_irq,
   input wire [7:0] port_data_lines_in,
   output reg [7:0] port_data_lines_out,
   output reg port_data_lines_oe,
   output reg strobe_n,
   output reg line_feed_n,
   output reg printer_reset_n,
   output reg printer_choose_n,
   input wire fault_n_in,
   input wire online_in,
   input wire out_of_media_in,
   input wire char_accepted_n_in,
   input wire busy_in
);

   // ==========================================================
   // input filter
   localparam SW = 27;
   localparam [SW-1:0] SRST = `PP_SYNC_RST;
   localparam [11:0] TMO = TMO_CYC[11:0];
   wire [SW-1:0] raw;
   reg [SW-1:0] s1_r;
   reg [SW-1:0] s2_r;
   reg [SW-1:0] s3_r;
   reg [SW-1:0] st_r;
   assign raw = {busy_in, char_accepted_n_in, out_of_media_in, online_in, fault_n_in,
                 host_wr_n, host_rd_n, host_cs_n, host_addr, host_data_in,
                 port_data_lines_in};
   // three flops per bit; a level counts once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
         always @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               s1_r[gi] <= SRST[gi];
               s2_r[gi] <= SRST[gi];
               s3_r[gi] <= SRST[gi];
               st_r[gi] <= SRST[gi];
            end else begin
               s1_r[gi] <= raw[gi];
               s2_r[gi] <= s1_r[gi];
               s3_r[gi] <= s2_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  st_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   wire [7:0] pd_s = st_r[7:0];
   wire [7:0] hd_s = st_r[15:8];
   wire [2:0] ha_s = st_r[18:16];
   wire cs_n_s = st_r[19];
   wire rd_n_s = st_r[20];
   wire wr_n_s = st_r[21];
   wire fault_s = st_r[22];
   wire online_s = st_r[23];
   wire media_s = st_r[24];
   wire ack_s = st_r[25];
   wire busy_s = st_r[26];

   // ==========================================================
   // strobe edges
   reg rd_n_d_r;
   reg wr_n_d_r;
   reg ack_d_r;
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_n_d_r <= 1'b1;
         wr_n_d_r <= 1'b1;
         ack_d_r <= 1'b1;
      end else begin
         rd_n_d_r <= rd_n_s;
         wr_n_d_r <= wr_n_s;
         ack_d_r <= ack_s;
      end
   end
   wire epp_mode = (port_mode == `PP_MODE_EPP);
   wire rd_lead = rd_n_d_r & ~rd_n_s & ~cs_n_s;
   wire rd_trail = ~rd_n_d_r & rd_n_s;
   wire wr_lead = wr_n_d_r & ~wr_n_s & ~cs_n_s;
   wire wr_trail = ~wr_n_d_r & wr_n_s & ~cs_n_s;
   wire ack_rise = ~ack_d_r & ack_s;
   // EPP ports decode only in EPP mode
   // EPP decode gate
   wire epp_sel = epp_mode & (ha_s >= `PP_OFF_EADDR);

   // ==========================================================
   // EPP cycle sequencer
   localparam [2:0] EP_IDLE = 3'h0;
   localparam [2:0] EP_SYNC = 3'h1;
   localparam [2:0] EP_STRB = 3'h2;
   localparam [2:0] EP_TERM = 3'h3;
   localparam [2:0] EP_DONE = 3'h4;
   reg [2:0] ep_state_r;
   reg [2:0] ep_state_nxt;
   reg ep_write_r;
   reg [2:0] ep_off_r;
   reg [11:0] ep_cnt_r;
   reg [7:0] ep_rdata_r;
   wire ep_busy = (ep_state_r != EP_IDLE) && (ep_state_r != EP_DONE);
   // wait input is active low on the busy pin in EPP mode
   wire wait_hi = busy_s;
   wire ep_expire = ep_busy && (ep_cnt_r >= TMO);
   always @* begin
      ep_state_nxt = ep_state_r;
      case (ep_state_r)
         EP_IDLE: begin
            if ((rd_lead | wr_lead) & epp_sel) begin
               ep_state_nxt = EP_SYNC;
            end
         end
         EP_SYNC: begin
            if (!wait_hi) begin
               ep_state_nxt = EP_STRB;
            end
         end
         EP_STRB: begin
            if (wait_hi) begin
               ep_state_nxt = EP_TERM;
            end
         end
         EP_TERM: begin
            ep_state_nxt = EP_DONE;
         end
         EP_DONE: begin
            if (rd_n_s & wr_n_s) begin
               ep_state_nxt = EP_IDLE;
            end
         end
         default: begin
            ep_state_nxt = EP_IDLE;
         end
      endcase
      // abort releases the host at once
      if (ep_expire) begin
         ep_state_nxt = EP_DONE;
      end
   end

   // read data latched at strobe end
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ep_state_r <= EP_IDLE;
         ep_write_r <= 1'b0;
         ep_off_r <= 3'h0;
         ep_cnt_r <= 12'h000;
         ep_rdata_r <= 8'h00;
      end else begin
         ep_state_r <= ep_state_nxt;
         if (ep_state_r == EP_IDLE) begin
            ep_write_r <= wr_lead;
            ep_off_r <= ha_s;
            ep_cnt_r <= 12'h000;
         end else if (ep_busy) begin
            ep_cnt_r <= ep_cnt_r + 12'h001;
         end
         if (ep_state_r == EP_STRB && wait_hi && !ep_write_r) begin
            ep_rdata_r <= pd_s;
         end
      end
   end

   // ==========================================================
   // registers
   reg [7:0] data_r;
   reg [5:0] ctrl_r;
   reg [7:0] eaddr_r;
   reg [7:0] edata_r [0:3];
   reg expired_r;
   // data latch on write trailing edge
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         data_r <= `PP_DATA_RST;
         ctrl_r <= `PP_CTRL_RST;
      end else if (wr_trail) begin
         if (ha_s == `PP_OFF_DATA) begin
            data_r <= hd_s;
         end
         if (ha_s == `PP_OFF_CTRL) begin
            ctrl_r <= hd_s[5:0];
         end
      end
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         eaddr_r <= `PP_EADDR_RST;
      end else if (wr_trail && epp_sel && ha_s == `PP_OFF_EADDR) begin
         eaddr_r <= hd_s;
      end
   end

   // one storage entry per EPP data port
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_edata
         always @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               edata_r[gi] <= `PP_EDATA_RST;
            end else if (wr_trail && epp_sel && ha_s == (`PP_OFF_EDATA0 + gi)) begin
               edata_r[gi] <= hd_s;
            end
         end
      end
   endgenerate

   // flag set wins over write-one clear
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         expired_r <= 1'b0;
      end else if (ep_expire && epp_mode) begin
         expired_r <= 1'b1;
      end else if (wr_trail && ha_s == `PP_OFF_STAT && hd_s[`PP_ST_EXPIRED]) begin
         expired_r <= 1'b0;
      end
   end

   // ==========================================================
   // host read data
   reg [7:0] rd_val;
   wire [7:0] stat_val = {~busy_s, ack_s, media_s, online_s, fault_s, 2'b00, expired_r};
   always @* begin
      rd_val = 8'h00;
      case (ha_s)
         `PP_OFF_DATA: rd_val = pd_s;
         `PP_OFF_STAT: rd_val = stat_val;
         // bits six and seven read low
         `PP_OFF_CTRL: rd_val = {2'b00, ctrl_r};
         default: rd_val = epp_mode ? ep_rdata_r : 8'h00;
      endcase
   end

   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         host_data_out <= 8'h00;
         host_data_oe <= 1'b0;
      end else begin
         if (rd_lead && ha_s != `PP_OFF_DATA) begin
            host_data_out <= rd_val;
         end else if (!rd_n_s && ha_s == `PP_OFF_DATA) begin
            host_data_out <= pd_s;
         end else if (!rd_n_s && ep_state_r == EP_TERM && !ep_write_r) begin
            host_data_out <= rd_val;
         end
         host_data_oe <= ~rd_n_s & ~cs_n_s & (epp_mode | ha_s < `PP_OFF_EADDR);
      end
   end

   // ==========================================================
   // connector and host outputs
   reg [7:0] pd_nxt;
   reg pd_oe_nxt;
   always @* begin
      pd_nxt = data_r;
      pd_oe_nxt = 1'b1;
      if (port_mode != `PP_MODE_PRINTER) begin
         pd_oe_nxt = ~ctrl_r[`PP_CT_DIR];
      end
      if (ep_busy || ep_state_r == EP_DONE) begin
         pd_nxt = hd_s;
         pd_oe_nxt = ep_write_r;
      end
      if (port_mode == `PP_MODE_PRINTER) begin
         pd_oe_nxt = 1'b1;
      end
   end

   wire strb_on = (ep_state_r == EP_STRB);
   wire adr_cyc = (ep_off_r == `PP_OFF_EADDR);
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         port_data_lines_out <= 8'h00;
         port_data_lines_oe <= 1'b1;
         strobe_n <= 1'b1;
         line_feed_n <= 1'b1;
         printer_reset_n <= 1'b0;
         printer_choose_n <= 1'b1;
         host_chrdy <= 1'b1;
         host_irq <= 1'b0;
      end else begin
         port_data_lines_out <= pd_nxt;
         port_data_lines_oe <= pd_oe_nxt;
         printer_reset_n <= ctrl_r[`PP_CT_PRST];
         if (ep_busy) begin
            // write, data and address strobe roles
            strobe_n <= ~ep_write_r & ~ctrl_r[`PP_CT_STROBE];
            line_feed_n <= ~(strb_on & ~adr_cyc);
            printer_choose_n <= ~(strb_on & adr_cyc);
         end else begin
            strobe_n <= ~ctrl_r[`PP_CT_STROBE];
            line_feed_n <= ~ctrl_r[`PP_CT_LINEFEED];
            printer_choose_n <= ~ctrl_r[`PP_CT_CHOOSE];
         end
         // ready low until cycle can finish
         host_chrdy <= ~(ep_busy && ep_state_nxt != EP_DONE) &
                       ~(rd_lead | wr_lead) | ~epp_sel;
         if (!ctrl_r[`PP_CT_IRQ]) begin
            host_irq <= 1'b0;
         end else if (ack_rise) begin
            host_irq <= 1'b1;
         end else if (!ack_s) begin
            host_irq <= 1'b0;
         end
      end
   end

endmodule

// *** testbench/pp_regs_monitor.sv ***
// Purpose: port checker for the parallel port registers
// Assumes: host holds the address until read enable drops
// Notes: a counter stands in for the long watchdog wait
`timescale 1ns/10ps
module pp_regs_monitor #(
   parameter TMO_CYC = 2000
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [1:0] port_mode,
   input wire logic host_rd_n,
   input wire logic [2:0] host_addr,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe,
   input wire logic host_chrdy,
   input wire logic host_irq,
   input wire logic port_data_lines_oe,
   input wire logic char_accepted_n_in
);
   logic [15:0] lo_cnt_r;
   // ========
   // stretch length; the watchdog must end it
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lo_cnt_r <= 16'h0000;
      end else begin
         lo_cnt_r <= host_chrdy ? 16'h0000 : lo_cnt_r + 16'h0001;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ========
   // checks
   chk_wdog_bound: assert property (lo_cnt_r <= TMO_CYC + 8)
      else $error("host stretch too long");
   chk_rd_release: assert property (host_rd_n [*7] |-> !host_data_oe)
      else $error("read enable left on");
   chk_prn_drive: assert property (port_mode == 2'h0 [*3] |-> port_data_lines_oe)
      else $error("printer mode lines not driven");
   chk_irq_cause: assert property ($rose(host_irq) |-> $past(char_accepted_n_in, 2))
      else $error("request without ack rise");
   chk_irq_drop: assert property (!char_accepted_n_in [*8] |-> !host_irq)
      else $error("request held with ack low");
   chk_stat_hold: assert property (host_data_oe && $past(host_data_oe) && host_addr == 3'h1
      |-> $stable(host_data_out))
      else $error("status moved during read");
   chk_stat_zero: assert property (host_data_oe && host_addr == 3'h1
      |-> host_data_out[2:1] == 2'h0)
      else $error("status bits 2:1 not zero");
   chk_ctrl_top: assert property (host_data_oe && host_addr == 3'h2
      |-> host_data_out[7:6] == 2'h0)
      else $error("control bits 7:6 not zero");
   chk_epp_gate: assert property (port_mode != 2'h2 && host_addr >= 3'h3
      |-> !host_data_oe && host_chrdy)
      else $error("enhanced port answered");
   chk_rdy_epp: assert property ($fell(host_chrdy) |-> port_mode == 2'h2)
      else $error("stretch outside enhanced mode");
endmodule

bind pp_regs pp_regs_monitor #(.TMO_CYC(TMO_CYC)) mon_u (.clk_sys(clk_sys), .reset(reset),
   .port_mode(port_mode), .host_rd_n(host_rd_n), .host_addr(host_addr),
   .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_chrdy(host_chrdy),
   .host_irq(host_irq), .port_data_lines_oe(port_data_lines_oe),
   .char_accepted_n_in(char_accepted_n_in));

// *** testbench/pp_prn_model.sv ***
// Purpose: connector-side peripheral for the parallel port bench
// Assumes: behavioural, sampled on the system clock
// Notes: hang withholds the handshake to force a watchdog abort
`timescale 1ns/10ps
module pp_prn_model (
   input wire logic clk_sys,
   input wire logic epp,
   input wire logic hang,
   input wire logic slow,
   input wire logic drv,
   input wire logic bsy,
   input wire logic [7:0] pat,
   input wire logic [7:0] dl_out,
   input wire logic dl_oe,
   input wire logic lf_n,
   input wire logic ch_n,
   output logic busy,
   output logic [7:0] lines,
   output logic [7:0] last_b,
   output logic last_a
);
   logic wt_r = 1'b0;
   logic stb_r = 1'b1;
   logic sa_r = 1'b0;
   logic [7:0] hold_r = 8'h00;
   logic [7:0] sh_r = 8'h00;
   logic [4:0] cnt_r = 5'h00;
   wire stb_n = lf_n & ch_n;
   // ========
   // undriven lines flip each cycle so stale data never passes
   assign lines = dl_oe ? dl_out : (drv || (epp && !stb_n)) ? pat : ~hold_r;
   assign busy = epp ? wt_r : bsy;
   // wait rises a few cycles after a strobe; captures byte at strobe end
   always @(posedge clk_sys) begin
      hold_r <= lines;
      stb_r <= stb_n;
      if (stb_n || !epp) begin
         cnt_r <= 5'h00;
         wt_r <= 1'b0;
      end else if (!hang) begin
         cnt_r <= cnt_r + 5'h01;
         if (cnt_r == (slow ? 5'h0c : 5'h02)) wt_r <= 1'b1;
      end
      if (!stb_n) begin
         sh_r <= lines;
         sa_r <= !ch_n;
      end else if (!stb_r) begin
         last_b <= sh_r;
         last_a <= sa_r;
      end
   end
endmodule

// *** testbench/tb_top.sv ***
// Purpose: register-level bench for the parallel port block
// Assumes: peripheral model on the connector side
// Notes: watchdog shortened to 40 cycles
`timescale 1ns/10ps
module tb_top;
   localparam TMO = 40;
   logic clk_sys, reset, cs_n, rd_n, wr_n, ft_n, onl, med, ack_n, bsy, hang, slow, drv;
   logic oe, rdy, irq, dl_oe, st_n, lf_n, pr_n, ch_n, busy, last_a, lowseen;
   logic [1:0] mode;
   logic [2:0] addr;
   logic [7:0] wdat, dout, dl_out, lines, last_b, pat;
   int error_cnt, num_checks, cyc;
   pp_regs #(.TMO_CYC(TMO)) dut_u (.clk_sys(clk_sys), .reset(reset), .port_mode(mode),
      .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_addr(addr),
      .host_data_in(wdat), .host_data_out(dout), .host_data_oe(oe), .host_chrdy(rdy),
      .host_irq(irq), .port_data_lines_in(lines), .port_data_lines_out(dl_out),
      .port_data_lines_oe(dl_oe), .strobe_n(st_n), .line_feed_n(lf_n),
      .printer_reset_n(pr_n), .printer_choose_n(ch_n), .fault_n_in(ft_n), .online_in(onl),
      .out_of_media_in(med), .char_accepted_n_in(ack_n), .busy_in(busy));
   pp_prn_model pm_u (.clk_sys(clk_sys), .epp(mode == 2'h2), .hang(hang), .slow(slow),
      .drv(drv), .bsy(bsy), .pat(pat), .dl_out(dl_out), .dl_oe(dl_oe), .lf_n(lf_n),
      .ch_n(ch_n), .busy(busy), .lines(lines), .last_b(last_b), .last_a(last_a));
   // ========
   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         summarize;
      end
   end
   // ========
   // host cycle helpers
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // strobe held until the stretch ends, bounded
   task automatic hold(input logic [2:0] a);
      int n;
      addr = a;
      cs_n = 1'b0;
      tick(6);
      lowseen = (rdy === 1'b0);
      for (n = 0; n < 300 && rdy !== 1'b1; n++) tick(1);
      chk("ready", 9'h001, {8'h00, rdy});
      tick(2);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      wdat = d;
      wr_n = 1'b0;
      hold(a);
      wr_n = 1'b1;
      tick(8);
      cs_n = 1'b1;
      tick(2);
   endtask
   task automatic rc(input string nm, input logic [2:0] a, input logic [8:0] e);
      rd_n = 1'b0;
      hold(a);
      chk(nm, e, {oe, dout});
      rd_n = 1'b1;
      tick(8);
      cs_n = 1'b1;
      tick(2);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ========
   // main sequence
   initial begin
      {reset, cs_n, rd_n, wr_n, ft_n, onl, med, ack_n} = 8'hff;
      {bsy, hang, slow, drv, mode, addr, wdat, pat} = 25'h000003c;
      tick(20);
      reset = 1'b0;
      tick(4);
      rc("data", 3'h0, 9'h100);
      rc("ctrl", 3'h2, 9'h100);
      chk("pins", 9'h00d, {5'h00, st_n, lf_n, pr_n, ch_n});
      wr(3'h0, 8'ha5);
      chk("lines", 9'h1a5, {dl_oe, dl_out});
      wr(3'h2, 8'hff);
      rc("ctrl", 3'h2, 9'h13f);
      chk("pins", 9'h002, {5'h00, st_n, lf_n, pr_n, ch_n});
      rc("data", 3'h0, 9'h1a5);
      mode = 2'h1;
      drv = 1'b1;
      rc("live", 3'h0, 9'h13c);
      chk("drive", 9'h000, {8'h00, dl_oe});
      drv = 1'b0;
      wr(3'h2, 8'h04);
      chk("drive", 9'h001, {8'h00, dl_oe});
      {ft_n, onl, med, ack_n, bsy} = 5'h15;
      rd_n = 1'b0;
      hold(3'h1);
      chk("stat", 9'h128, {oe, dout});
      // status pins move mid-read; the returned byte must not
      {ft_n, onl, med, ack_n, bsy} = 5'h0a;
      tick(8);
      chk("stat hold", 9'h128, {oe, dout});
      rd_n = 1'b1;
      tick(8);
      cs_n = 1'b1;
      tick(2);
      {ft_n, onl, med, ack_n, bsy} = 5'h0a;
      rc("stat", 3'h1, 9'h1d0);
      chk("irq", 9'h000, {8'h00, irq});
      wr(3'h2, 8'h14);
      ack_n = 1'b0;
      tick(10);
      ack_n = 1'b1;
      tick(10);
      chk("irq", 9'h001, {8'h00, irq});
      ack_n = 1'b0;
      tick(10);
      chk("irq", 9'h000, {8'h00, irq});
      ack_n = 1'b1;
      wr(3'h2, 8'h04);
      for (int a = 3; a < 8; a++) rc("off", 3'(a), 9'h000);
      wr(3'h4, 8'h77);
      chk("stretch", 9'h000, {8'h00, lowseen});
      mode = 2'h2;
      wr(3'h3, 8'hc3);
      chk("stretch", 9'h001, {8'h00, lowseen});
      chk("addr out", 9'h1c3, {last_a, last_b});
      slow = 1'b1;
      wr(3'h5, 8'h5a);
      slow = 1'b0;
      chk("data out", 9'h05a, {last_a, last_b});
      rc("addr in", 3'h3, 9'h13c);
      rc("data in", 3'h6, 9'h13c);
      rc("stat", 3'h1, 9'h1d0);
      hang = 1'b1;
      wr(3'h3, 8'h11);
      hang = 1'b0;
      rc("stat", 3'h1, 9'h1d1);
      wr(3'h1, 8'h00);
      rc("stat", 3'h1, 9'h1d1);
      wr(3'h1, 8'h01);
      rc("stat", 3'h1, 9'h1d0);
      rc("stat", 3'h1, 9'h1d0);
      summarize;
   end
endmodule
